// File: logic/smon_pkg.sv
package smon_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int REG_AW = 8;
  localparam int REG_DW = 8;
  localparam int THR_W  = 4;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_PRODUCT_ID_HIGH    = 8'h00;
  localparam logic [7:0] OFS_PRODUCT_ID_LOW     = 8'h01;
  localparam logic [7:0] OFS_SILICON_REVISION   = 8'h02;
  localparam logic [7:0] OFS_OTP_CONFIG_VERSION = 8'h03;
  localparam logic [7:0] OFS_MONITOR_THRESHOLD  = 8'h10;
  localparam logic [7:0] OFS_MONITOR_ENABLE     = 8'h11;
  localparam logic [7:0] OFS_EVENT_STATUS       = 8'h12;
  localparam logic [7:0] OFS_EVENT_MASK         = 8'h13;
  localparam logic [7:0] OFS_POWER_STATE        = 8'h14;
  localparam logic [7:0] UNMAPPED_VALUE         = 8'hFF;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int EVT_MONITOR = 0;
  localparam int EVT_BUS     = 1;
  localparam int EVT_W       = 2;
  localparam logic [THR_W-1:0] MON_THR_RESET  = 4'h0;
  localparam logic [EVT_W-1:0] EVT_MASK_RESET = 2'h3;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ          = 10;
  localparam int DEGLITCH_US      = 180;
  localparam int DEBOUNCE_US      = 125;
  localparam int POR_SAMPLE_MS    = 1;
  localparam int DEGLITCH_CYC     = DEGLITCH_US * CLK_MHZ;
  localparam int DEBOUNCE_CYC     = DEBOUNCE_US * CLK_MHZ;
  localparam int POR_SAMPLE_CYC   = POR_SAMPLE_MS * 1000 * CLK_MHZ;
  localparam int TIMER_W          = 11;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_UNPOWERED = 5'h01,
    ST_BACKUP    = 5'h02,
    ST_OFF       = 5'h04,
    ST_ACTIVE    = 5'h08,
    ST_SLEEP     = 5'h10
  } smon_state_e;

  typedef struct packed {
    logic por_ok;
    logic above_low;
    logic mon_above;
    logic bus_above;
  } smon_cmp_s;

  typedef struct packed {
    logic [THR_W-1:0]  low_thr;
    logic [THR_W-1:0]  start_thr;
    logic              sense_buffer;
    logic [REG_DW-1:0] version;
  } smon_otp_s;

endpackage

// File: logic/smon_supply_monitor.sv
`timescale 1ns/1ns
`default_nettype none

module smon_supply_monitor #(
  parameter int               POR_SAMPLE_CYCLES = smon_pkg::POR_SAMPLE_CYC,
  // identity values are arbitrary
  parameter logic [7:0]       PRODUCT_ID_HIGH   = 8'hA5,
  parameter logic [7:0]       PRODUCT_ID_LOW    = 8'h3C,
  parameter logic [7:0]       SILICON_REVISION  = 8'h02
) (
  input  wire logic                              clock,
  input  wire logic                              rst,
  input  wire logic                              clock_enable,
  input  wire smon_pkg::smon_cmp_s               cmp_in,
  input  wire smon_pkg::smon_otp_s               otp_in,
  input  wire logic                              on_request,
  input  wire logic                              off_request,
  input  wire logic                              sleep_request,
  input  wire logic                              wake_request,
  input  wire logic [smon_pkg::REG_AW-1:0]       reg_addr,
  input  wire logic                              reg_wr,
  input  wire logic                              reg_rd,
  input  wire logic [smon_pkg::REG_DW-1:0]       reg_wdata,
  output logic      [smon_pkg::REG_DW-1:0]       reg_rdata,
  output logic      [4:0]                        power_state,
  output logic                                   regulators_enable,
  output logic                                   always_on_enable,
  output logic                                   monitor_enable,
  output logic      [smon_pkg::THR_W-1:0]        monitor_threshold,
  output logic      [smon_pkg::THR_W-1:0]        low_supply_threshold,
  output logic                                   sense_buffer_enable,
  output logic                                   sense_bypass,
  output logic                                   event_pending
);

  localparam int POR_W = $clog2(POR_SAMPLE_CYCLES + 1);
  localparam logic [POR_W-1:0] POR_LAST =
    POR_W'(POR_SAMPLE_CYCLES - 1);
  localparam logic [smon_pkg::TIMER_W-1:0] DEGLITCH_LAST =
    smon_pkg::TIMER_W'(smon_pkg::DEGLITCH_CYC - 1);
  localparam logic [smon_pkg::TIMER_W-1:0] DEBOUNCE_LOAD =
    smon_pkg::TIMER_W'(smon_pkg::DEBOUNCE_CYC - 1);

  function automatic logic addr_is(
    input logic [smon_pkg::REG_AW-1:0] a,
    input logic [7:0]                  ofs
  );
    addr_is = (a == ofs);
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  smon_pkg::smon_cmp_s cmp_meta;
  smon_pkg::smon_cmp_s cmp_sync;

  always_ff @(posedge clock) begin
    if (rst) begin
      cmp_meta <= '0;
      cmp_sync <= '0;
    end else if (clock_enable) begin
      cmp_meta <= cmp_in;
      cmp_sync <= cmp_meta;
    end
  end

  // ----------------------------------------------------------------
  // otp capture
  // ----------------------------------------------------------------
  // otp thresholds are loaded only here; after start-up the monitor threshold comes from mon_thr, which has a register write path
  smon_pkg::smon_otp_s otp_q;

  always_ff @(posedge clock) begin
    if (rst) begin
      otp_q <= otp_in;
    end
  end

  // ----------------------------------------------------------------
  // power-on supply sampling
  // ----------------------------------------------------------------
  // a dip that starts and ends between two ticks is not seen
  logic [POR_W-1:0] por_cnt;
  logic             por_level;
  logic             por_tick;

  assign por_tick = (por_cnt == POR_LAST);

  always_ff @(posedge clock) begin
    if (rst) begin
      por_cnt   <= '0;
      por_level <= 1'b0;
    end else if (clock_enable) begin
      por_cnt <= por_tick ? '0 : por_cnt + POR_W'(1);
      if (por_tick) begin
        por_level <= cmp_sync.por_ok;
      end
    end
  end

  // ----------------------------------------------------------------
  // low supply deglitch
  // ----------------------------------------------------------------
  smon_pkg::smon_state_e state;
  smon_pkg::smon_state_e next_state;
  logic [smon_pkg::TIMER_W-1:0] low_cnt;
  logic                         low_trip;
  logic                         low_watch;

  assign low_watch = (state == smon_pkg::ST_OFF) ||
                     (state == smon_pkg::ST_ACTIVE) ||
                     (state == smon_pkg::ST_SLEEP);
  assign low_trip  = low_watch && !cmp_sync.above_low &&
                     (low_cnt == DEGLITCH_LAST);

  always_ff @(posedge clock) begin
    if (rst) begin
      low_cnt <= '0;
    end else if (clock_enable) begin
      if (!low_watch || cmp_sync.above_low || low_trip) begin
        low_cnt <= '0;
      end else begin
        low_cnt <= low_cnt + smon_pkg::TIMER_W'(1);
      end
    end
  end

  // ----------------------------------------------------------------
  // event detection
  // ----------------------------------------------------------------
  logic                         mon_prev;
  logic                         bus_prev;
  logic [smon_pkg::TIMER_W-1:0] debounce_cnt;
  logic                         powered_up;
  logic                         mon_en;
  logic                         mon_event;
  logic                         bus_event;

  assign mon_event = powered_up && mon_en &&
                     (cmp_sync.mon_above != mon_prev) &&
                     (debounce_cnt == '0);
  assign bus_event = (state != smon_pkg::ST_UNPOWERED) &&
                     (cmp_sync.bus_above != bus_prev);

  always_ff @(posedge clock) begin
    if (rst) begin
      mon_prev     <= 1'b0;
      bus_prev     <= 1'b0;
      debounce_cnt <= '0;
    end else if (clock_enable) begin
      mon_prev <= cmp_sync.mon_above;
      bus_prev <= cmp_sync.bus_above;
      if (mon_event) begin
        debounce_cnt <= DEBOUNCE_LOAD;
      end else if (debounce_cnt != '0) begin
        debounce_cnt <= debounce_cnt - smon_pkg::TIMER_W'(1);
      end
    end
  end

  // ----------------------------------------------------------------
  // power state machine
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      smon_pkg::ST_UNPOWERED: begin
        if (por_level) begin
          next_state = smon_pkg::ST_BACKUP;
        end
      end
      smon_pkg::ST_BACKUP: begin
        if (cmp_sync.above_low) begin
          next_state = smon_pkg::ST_OFF;
        end
      end
      smon_pkg::ST_OFF: begin
        if (low_trip) begin
          next_state = smon_pkg::ST_BACKUP;
        end else if ((on_request || bus_event) &&
                     cmp_sync.mon_above) begin
          next_state = smon_pkg::ST_ACTIVE;
        end
      end
      smon_pkg::ST_ACTIVE: begin
        if (low_trip) begin
          next_state = smon_pkg::ST_BACKUP;
        end else if (off_request) begin
          next_state = smon_pkg::ST_OFF;
        end else if (sleep_request) begin
          next_state = smon_pkg::ST_SLEEP;
        end
      end
      smon_pkg::ST_SLEEP: begin
        if (low_trip) begin
          next_state = smon_pkg::ST_BACKUP;
        end else if (off_request) begin
          next_state = smon_pkg::ST_OFF;
        end else if (bus_event || wake_request) begin
          next_state = smon_pkg::ST_ACTIVE;
        end
      end
      default: begin
        next_state = smon_pkg::ST_UNPOWERED;
      end
    endcase
    if (!por_level) begin
      next_state = smon_pkg::ST_UNPOWERED;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state <= smon_pkg::ST_UNPOWERED;
    end else if (clock_enable) begin
      state <= next_state;
    end
  end

  // powered_up marks that start-up finished; cleared when rails drop
  always_ff @(posedge clock) begin
    if (rst) begin
      powered_up <= 1'b0;
    end else if (clock_enable) begin
      if (next_state == smon_pkg::ST_ACTIVE) begin
        powered_up <= 1'b1;
      end else if ((next_state != smon_pkg::ST_SLEEP) &&
                   (next_state != smon_pkg::ST_ACTIVE)) begin
        powered_up <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  logic [smon_pkg::THR_W-1:0] mon_thr;
  logic [smon_pkg::EVT_W-1:0] evt_status;
  logic [smon_pkg::EVT_W-1:0] evt_mask;
  logic [smon_pkg::EVT_W-1:0] evt_set;
  logic [smon_pkg::EVT_W-1:0] evt_clr;
  logic                       startup_done;

  assign startup_done = !powered_up &&
                        (next_state == smon_pkg::ST_ACTIVE);

  always_comb begin
    evt_set = '0;
    evt_set[smon_pkg::EVT_MONITOR] = mon_event;
    evt_set[smon_pkg::EVT_BUS]     = bus_event;
    evt_clr = '0;
    if (reg_wr && addr_is(reg_addr, smon_pkg::OFS_EVENT_STATUS)) begin
      evt_clr = reg_wdata[smon_pkg::EVT_W-1:0];
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      mon_thr  <= smon_pkg::MON_THR_RESET;
      evt_mask <= smon_pkg::EVT_MASK_RESET;
    end else if (clock_enable && reg_wr) begin
      if (addr_is(reg_addr, smon_pkg::OFS_MONITOR_THRESHOLD)) begin
        mon_thr <= reg_wdata[smon_pkg::THR_W-1:0];
      end
      if (addr_is(reg_addr, smon_pkg::OFS_EVENT_MASK)) begin
        evt_mask <= reg_wdata[smon_pkg::EVT_W-1:0];
      end
    end
  end

  // start-up wins over a same-cycle software enable
  always_ff @(posedge clock) begin
    if (rst) begin
      mon_en <= 1'b0;
    end else if (clock_enable) begin
      if (startup_done) begin
        mon_en <= 1'b0;
      end else if (reg_wr &&
                   addr_is(reg_addr, smon_pkg::OFS_MONITOR_ENABLE)) begin
        mon_en <= reg_wdata[0];
      end
    end
  end

  // set wins over clear so an event in the clear cycle survives
  always_ff @(posedge clock) begin
    if (rst) begin
      evt_status <= '0;
    end else if (clock_enable) begin
      evt_status <= (evt_status & ~evt_clr) | evt_set;
    end
  end

  // ----------------------------------------------------------------
  // register read
  // ----------------------------------------------------------------
  logic [smon_pkg::REG_DW-1:0] rd_mux;

  always_comb begin
    rd_mux = smon_pkg::UNMAPPED_VALUE;
    case (reg_addr)
      smon_pkg::OFS_PRODUCT_ID_HIGH:    rd_mux = PRODUCT_ID_HIGH;
      smon_pkg::OFS_PRODUCT_ID_LOW:     rd_mux = PRODUCT_ID_LOW;
      smon_pkg::OFS_SILICON_REVISION:   rd_mux = SILICON_REVISION;
      smon_pkg::OFS_OTP_CONFIG_VERSION: rd_mux = otp_q.version;
      smon_pkg::OFS_MONITOR_THRESHOLD: begin
        rd_mux = {{(smon_pkg::REG_DW-smon_pkg::THR_W){1'b0}}, mon_thr};
      end
      smon_pkg::OFS_MONITOR_ENABLE: begin
        rd_mux = {{(smon_pkg::REG_DW-1){1'b0}}, mon_en};
      end
      smon_pkg::OFS_EVENT_STATUS: begin
        rd_mux = {{(smon_pkg::REG_DW-smon_pkg::EVT_W){1'b0}}, evt_status};
      end
      smon_pkg::OFS_EVENT_MASK: begin
        rd_mux = {{(smon_pkg::REG_DW-smon_pkg::EVT_W){1'b0}}, evt_mask};
      end
      smon_pkg::OFS_POWER_STATE: begin
        rd_mux = {3'h0, state};
      end
      default: begin
        rd_mux = smon_pkg::UNMAPPED_VALUE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      reg_rdata <= '0;
    end else if (clock_enable && reg_rd) begin
      reg_rdata <= rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------
  // before start-up the comparator guards power-on with the otp level
  always_ff @(posedge clock) begin
    if (rst) begin
      power_state          <= smon_pkg::ST_UNPOWERED;
      regulators_enable    <= 1'b0;
      always_on_enable     <= 1'b0;
      monitor_enable       <= 1'b0;
      monitor_threshold    <= '0;
      low_supply_threshold <= '0;
      sense_buffer_enable  <= 1'b0;
      sense_bypass         <= 1'b1;
      event_pending        <= 1'b0;
    end else if (clock_enable) begin
      power_state       <= next_state;
      regulators_enable <= (next_state == smon_pkg::ST_ACTIVE) ||
                           (next_state == smon_pkg::ST_SLEEP);
      always_on_enable  <= (next_state != smon_pkg::ST_UNPOWERED);
      if (powered_up) begin
        monitor_enable    <= mon_en;
        monitor_threshold <= mon_thr;
      end else begin
        monitor_enable    <= (state == smon_pkg::ST_OFF);
        monitor_threshold <= otp_q.start_thr;
      end
      low_supply_threshold <= otp_q.low_thr;
      sense_buffer_enable  <= otp_q.sense_buffer;
      sense_bypass         <= !otp_q.sense_buffer;
      event_pending        <= |(evt_status & ~evt_mask);
    end
  end

endmodule

`default_nettype wire

// File: dv/smon_checker.sv
`timescale 1ns/1ns
`default_nettype none

module smon_checker #(
  parameter logic [7:0] PRODUCT_ID_HIGH = 8'hA5
) (
  input wire logic                        clock,
  input wire logic                        rst,
  input wire logic                        clock_enable,
  input wire smon_pkg::smon_cmp_s         cmp_in,
  input wire logic [smon_pkg::REG_AW-1:0] reg_addr,
  input wire logic                        reg_rd,
  input wire logic [smon_pkg::REG_DW-1:0] reg_rdata,
  input wire logic [4:0]                  power_state,
  input wire logic                        regulators_enable,
  input wire logic                        always_on_enable,
  input wire logic                        monitor_enable,
  input wire logic [smon_pkg::THR_W-1:0]  low_supply_threshold,
  input wire logic                        sense_buffer_enable,
  input wire logic                        sense_bypass
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // counts raw low time; runs ahead of the synced copy, so a bound is safe
  logic [11:0] low_run;
  logic        mapped;
  always_ff @(posedge clock) begin
    if (rst || cmp_in.above_low) begin
      low_run <= 12'h000;
    end else if (low_run != 12'hFFF) begin
      low_run <= low_run + 12'h001;
    end
  end
  assign mapped = (reg_addr <= 8'h03) ||
                  (reg_addr >= 8'h10 && reg_addr <= 8'h14);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  chk_aon_state: assert property (
    $stable(power_state) |-> always_on_enable == (power_state != 5'h01))
    else $error("always-on enable disagrees with state");
  chk_regs_state: assert property (
    $stable(power_state) |->
      regulators_enable == (power_state inside {5'h08, 5'h10}))
    else $error("regulator enable disagrees with state");
  chk_reset_state: assert property (
    $fell(rst) |-> power_state == 5'h01 && !regulators_enable)
    else $error("reset did not leave the unpowered state");
  chk_low_thr_fixed: assert property (
    !$past(rst) && !$past(rst, 2) |-> $stable(low_supply_threshold))
    else $error("low threshold changed outside reset");
  chk_sense_path: assert property (
    sense_buffer_enable != sense_bypass)
    else $error("sense buffer and bypass both set or both clear");
  chk_deglitch_hold: assert property (
    power_state == 5'h02 && $past(power_state) inside {5'h04, 5'h08, 5'h10}
      |-> low_run >= 12'd1800)
    else $error("backup entered before the deglitch time");
  chk_backup_drop: assert property (
    power_state == 5'h02 && $past(power_state) == 5'h08
      |-> ##[0:1] !regulators_enable && always_on_enable)
    else $error("regulators not dropped on the way to backup");
  chk_startup_mon: assert property (
    power_state == 5'h08 && $past(power_state) == 5'h04
      |-> ##[0:1] !monitor_enable)
    else $error("monitor left enabled after start-up");
  chk_unmapped_ff: assert property (
    reg_rd && clock_enable && !mapped |=> reg_rdata == 8'hFF)
    else $error("unmapped read not all ones");
  chk_id_high: assert property (
    reg_rd && clock_enable && reg_addr == 8'h00
      |=> reg_rdata == PRODUCT_ID_HIGH)
    else $error("product id high read wrong");
endmodule

bind smon_supply_monitor smon_checker #(
  .PRODUCT_ID_HIGH(PRODUCT_ID_HIGH)
) u_smon_checker (
  .clock(clock), .rst(rst), .clock_enable(clock_enable),
  .cmp_in(cmp_in), .reg_addr(reg_addr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .power_state(power_state),
  .regulators_enable(regulators_enable),
  .always_on_enable(always_on_enable), .monitor_enable(monitor_enable),
  .low_supply_threshold(low_supply_threshold),
  .sense_buffer_enable(sense_buffer_enable), .sense_bypass(sense_bypass));

`default_nettype wire

// File: dv/smon_rail_model.sv
`timescale 1ns/1ns
`default_nettype none

module smon_rail_model #(
  parameter logic [4:0] POR_LEVEL = 5'h01
) (
  input  wire logic [4:0]                 supply_level,
  input  wire logic [4:0]                 sense_level,
  input  wire logic                       bus_present,
  input  wire logic [smon_pkg::THR_W-1:0] low_thr,
  input  wire logic [smon_pkg::THR_W-1:0] mon_thr,
  output var  smon_pkg::smon_cmp_s        cmp_out
);
  // ideal comparators with no hysteresis; a level equal to the low or monitor threshold reads as not above
  always_comb begin
    cmp_out.por_ok    = supply_level >= POR_LEVEL;
    cmp_out.above_low = supply_level > {1'b0, low_thr};
    cmp_out.mon_above = sense_level > {1'b0, mon_thr};
    cmp_out.bus_above = bus_present;
  end
endmodule

`default_nettype wire

// File: dv/smon_supply_monitor_bench.sv
`timescale 1ns/1ns
`default_nettype none

module smon_supply_monitor_bench;
  localparam int         POR_CYC = 8;
  // identity values are arbitrary
  localparam logic [7:0] ID_HI   = 8'h6E;
  localparam logic [7:0] ID_LO   = 8'h2B;
  localparam logic [7:0] SI_REV  = 8'h04;
  localparam logic [4:0] S_UNP   = smon_pkg::ST_UNPOWERED;
  localparam logic [4:0] S_BAK   = smon_pkg::ST_BACKUP;
  localparam logic [4:0] S_OFF   = smon_pkg::ST_OFF;
  localparam logic [4:0] S_ACT   = smon_pkg::ST_ACTIVE;
  localparam logic [4:0] S_SLP   = smon_pkg::ST_SLEEP;
  logic clock, rst, clock_enable, on_request, off_request, sleep_request;
  logic wake_request, reg_wr, reg_rd, bus_present, regulators_enable;
  logic always_on_enable, monitor_enable, sense_buffer_enable;
  logic sense_bypass, event_pending;
  logic [7:0]          reg_addr, reg_wdata, reg_rdata, rdata;
  logic [4:0]          supply_level, sense_level, power_state;
  logic [3:0]          monitor_threshold, low_supply_threshold, thr;
  smon_pkg::smon_cmp_s cmp_in;
  smon_pkg::smon_otp_s otp_in;
  int                  miscompares, checks_done;
  int unsigned         seed;

  smon_supply_monitor #(.POR_SAMPLE_CYCLES(POR_CYC), .PRODUCT_ID_HIGH(ID_HI),
    .PRODUCT_ID_LOW(ID_LO), .SILICON_REVISION(SI_REV)) u_smon_supply_monitor (
    .clock(clock), .rst(rst), .clock_enable(clock_enable), .cmp_in(cmp_in),
    .otp_in(otp_in), .on_request(on_request), .off_request(off_request),
    .sleep_request(sleep_request), .wake_request(wake_request),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .power_state(power_state),
    .regulators_enable(regulators_enable), .always_on_enable(always_on_enable),
    .monitor_enable(monitor_enable), .monitor_threshold(monitor_threshold),
    .low_supply_threshold(low_supply_threshold),
    .sense_buffer_enable(sense_buffer_enable), .sense_bypass(sense_bypass),
    .event_pending(event_pending));
  smon_rail_model u_smon_rail_model (.supply_level(supply_level),
    .sense_level(sense_level), .bus_present(bus_present),
    .low_thr(low_supply_threshold), .mon_thr(monitor_threshold),
    .cmp_out(cmp_in));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  // read data is picked up one edge after the request edge, where it holds
  task automatic reg_access(input logic wr, input logic [7:0] a,
                            input logic [7:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= wr;
    reg_rd    <= !wr;
    tick(1);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    tick(1);
    rdata = reg_rdata;
  endtask
  task automatic wait_state(input logic [4:0] st, input int bound);
    int n;
    n = 0;
    while (power_state !== st && n < bound) begin
      tick(1);
      n++;
    end
    check({3'h0, power_state}, {3'h0, st});
    if (power_state !== st) begin
      complete_run();
    end
  endtask
  function automatic logic [7:0] reg_expect(input logic [7:0] a);
    case (a)
      smon_pkg::OFS_PRODUCT_ID_HIGH:    reg_expect = ID_HI;
      smon_pkg::OFS_PRODUCT_ID_LOW:     reg_expect = ID_LO;
      smon_pkg::OFS_SILICON_REVISION:   reg_expect = SI_REV;
      smon_pkg::OFS_OTP_CONFIG_VERSION: reg_expect = otp_in.version;
      default:                          reg_expect = smon_pkg::UNMAPPED_VALUE;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  initial begin
    logic [7:0] addrs [6];
    seed = $urandom(24);
    {rst, clock_enable} = 2'b11;
    {on_request, off_request, sleep_request, wake_request} = 4'h0;
    {reg_wr, reg_rd, bus_present, reg_addr, reg_wdata} = 19'h0;
    {supply_level, sense_level, miscompares, checks_done} = '0;
    otp_in.low_thr = 4'(1 + $urandom % 8);
    otp_in.start_thr = 4'(2 + $urandom % 8);
    otp_in.sense_buffer = 1'($urandom);
    otp_in.version = 8'($urandom);
    addrs = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h0F, 8'(8'h20 + $urandom % 8'hE0)};
    tick(12);
    rst <= 1'b0;
    tick(3);
    check(low_supply_threshold, otp_in.low_thr);
    check(monitor_threshold, otp_in.start_thr);
    check(sense_buffer_enable, otp_in.sense_buffer);
    tick(3 * POR_CYC);
    wait_state(S_UNP, 0);
    foreach (addrs[i]) begin
      reg_access(1'b0, addrs[i], 8'h00);
      check(rdata, reg_expect(addrs[i]));
    end
    reg_access(1'b1, smon_pkg::OFS_PRODUCT_ID_LOW, ~ID_LO);
    reg_access(1'b0, smon_pkg::OFS_PRODUCT_ID_LOW, 8'h00);
    check(rdata, ID_LO);
    // supply at or above reset level but equal to the low threshold
    supply_level <= {1'b0, otp_in.low_thr};
    wait_state(S_BAK, POR_CYC + 6);
    tick(20);
    wait_state(S_BAK, 0);
    supply_level <= 5'(5'h10 + $urandom % 16);
    wait_state(S_OFF, 8);
    sense_level <= {1'b0, otp_in.start_thr};
    on_request <= 1'b1;
    tick(10);
    wait_state(S_OFF, 0);
    sense_level <= {1'b0, otp_in.start_thr} + 5'h01;
    wait_state(S_ACT, 6);
    on_request <= 1'b0;
    tick(2);
    check(monitor_enable, 1'b0);
    check(monitor_threshold, smon_pkg::MON_THR_RESET);
    thr = 4'(4 + $urandom % 8);
    sense_level <= 5'h00;
    reg_access(1'b1, smon_pkg::OFS_MONITOR_THRESHOLD, {4'h0, thr});
    tick(1);
    check(monitor_threshold, thr);
    reg_access(1'b1, smon_pkg::OFS_EVENT_MASK, 8'h00);
    sense_level <= {1'b0, thr} + 5'h01;
    tick(6);
    reg_access(1'b0, smon_pkg::OFS_EVENT_STATUS, 8'h00);
    check(rdata, 8'h00);
    reg_access(1'b1, smon_pkg::OFS_MONITOR_ENABLE, 8'h01);
    sense_level <= 5'h00;
    tick(6);
    check(event_pending, 1'b1);
    reg_access(1'b1, smon_pkg::OFS_EVENT_STATUS, 8'h01);
    sense_level <= {1'b0, thr} + 5'h01;
    tick(20);
    reg_access(1'b0, smon_pkg::OFS_EVENT_STATUS, 8'h00);
    check(rdata, 8'h00);
    tick(smon_pkg::DEBOUNCE_CYC);
    sense_level <= 5'h00;
    tick(6);
    reg_access(1'b1, smon_pkg::OFS_EVENT_MASK, 8'h01);
    tick(1);
    check(event_pending, 1'b0);
    reg_access(1'b0, smon_pkg::OFS_EVENT_STATUS, 8'h00);
    check(rdata, 8'h01);
    reg_access(1'b1, smon_pkg::OFS_EVENT_STATUS, 8'h03);
    sleep_request <= 1'b1;
    wait_state(S_SLP, 6);
    sleep_request <= 1'b0;
    bus_present <= 1'b1;
    wait_state(S_ACT, 8);
    tick(2);
    check(event_pending, 1'b1);
    off_request <= 1'b1;
    wait_state(S_OFF, 6);
    off_request <= 1'b0;
    sense_level <= 5'h1F;
    tick(4);
    bus_present <= 1'b0;
    wait_state(S_ACT, 8);
    // a frozen clock enable must hold off a pending request
    clock_enable <= 1'b0;
    off_request  <= 1'b1;
    tick(5);
    wait_state(S_ACT, 0);
    clock_enable <= 1'b1;
    off_request  <= 1'b0;
    // a dip shorter than the deglitch time is ignored
    supply_level <= {1'b0, otp_in.low_thr};
    tick(smon_pkg::DEGLITCH_CYC - 300);
    supply_level <= 5'h1F;
    tick(4);
    wait_state(S_ACT, 0);
    supply_level <= {1'b0, otp_in.low_thr};
    tick(smon_pkg::DEGLITCH_CYC - 20);
    wait_state(S_ACT, 0);
    wait_state(S_BAK, 40);
    tick(2);
    check(regulators_enable, 1'b0);
    check(always_on_enable, 1'b1);
    supply_level <= 5'h00;
    wait_state(S_UNP, POR_CYC + 6);
    tick(2);
    check(always_on_enable, 1'b0);
    tick(50);
    supply_level <= 5'h1F;
    wait_state(S_BAK, POR_CYC + 6);
    wait_state(S_OFF, 8);
    rst <= 1'b1;
    tick(3);
    wait_state(S_UNP, 0);
    rst <= 1'b0;
    tick(3);
    check(low_supply_threshold, otp_in.low_thr);
    complete_run();
  end
endmodule

`default_nettype wire
